// ===== design/sio_consts.svh
// register offsets, field positions, codes and reset values of the simple io server
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH
`define SIO_OFF_PAYLOAD_LAST 8'h07
`define SIO_OFF_ADDR_HIGH 8'h08
`define SIO_OFF_ADDR_LOW 8'h09
`define SIO_OFF_OFFS_HIGH 8'h0A
`define SIO_OFF_OFFS_LOW 8'h0B
`define SIO_OFF_CTRL 8'h0C
`define SIO_OFF_STATUS 8'h0D
`define SIO_OFF_ERROR 8'h0E
`define SIO_OFF_IRQ_STAT 8'h0F
`define SIO_OFF_IRQ_MASK 8'h10
`define SIO_BIT_READ 6
`define SIO_BIT_INDIRECT 5
`define SIO_BIT_LAUNCH 0
`define SIO_RID_ACCESS 10'h200
`define SIO_RID_MANAGE 10'h201
`define SIO_DATA_SIZE 8'h04
`define SIO_DATA_TYPE 8'h05
`define SIO_ACCESS_RD_LEVEL 8'h00
`define SIO_ACCESS_WR_LEVEL 8'h00
`define SIO_MANAGE_RD_LEVEL 8'h00
`define SIO_MANAGE_WR_LEVEL 8'h02
`define SIO_IO_MAX 15'h007F
`define SIO_MG_FILTER0 15'h0000
`define SIO_MG_FILTER1 15'h0001
`define SIO_MG_EMUL 15'h0100
`define SIO_WEIGHT_MIN 8'h01
`define SIO_WEIGHT_MAX 8'h64
`define SIO_WEIGHT_RESET 7'h64
`define SIO_LEVEL_HIGH 8'h01
`define SIO_ERR_NONE 8'h00
`define SIO_ERR_DIRECTION 8'h41
`define SIO_ERR_LEVEL 8'h42
`define SIO_ERR_RANGE 8'h43
`define SIO_ERR_VALUE 8'h44
`define SIO_ERR_RID 8'h45
`define SIO_ERR_ACCESS 8'h46
`endif

// ===== design/sio_pkg.sv
// types shared by the simple io server modules
package sio_pkg;
    typedef struct packed {
        logic read;
        logic indirect;
        logic [9:0] resource_identifier;
        logic [14:0] offset;
    } sio_msg_s;
    typedef struct packed {
        logic [15:0] ch1;
        logic [15:0] ch0;
    } sio_pair_s;
    typedef logic [1:0][6:0] sio_weights_t;
endpackage

// ===== design/sio_filter.sv
// per-channel low pass filter with a percentage weight for new samples
`timescale 1ns/10ps
module sio_filter
    import sio_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic valid_in,
    input wire sio_pair_s sample_in,
    input wire sio_weights_t weight_in,
    output sio_pair_s avg_out
);
    typedef struct packed {
        sio_pair_s avg;
    } sio_flt_state_s;
    sio_flt_state_s s_r;
    sio_flt_state_s s_nxt;

    // weight w: avg = (w*x + (100-w)*avg)/100; truncation biases slightly low
    function automatic logic [15:0] blend(input logic [15:0] x, input logic [15:0] a,
                                          input logic [6:0] w);
        logic [23:0] sum;
        sum = 24'(x) * 24'(w) + 24'(a) * 24'(7'h64 - w);
        return 16'(sum / 24'h000064);
    endfunction

    always_comb begin
        s_nxt = s_r;
        if (valid_in) begin
            s_nxt.avg.ch0 = blend(sample_in.ch0, s_r.avg.ch0, weight_in[0]); // R8 R9 R10
            s_nxt.avg.ch1 = blend(sample_in.ch1, s_r.avg.ch1, weight_in[1]); // R8 R9 R10
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avg_out = s_r.avg;

    property p_no_filter;
        @(posedge clk_in) disable iff (!rst_n_in)
        (valid_in && weight_in[0] == 7'd100) |=> (avg_out.ch0 == $past(sample_in.ch0));
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("weight 100 did not pass sample"); // R9
endmodule // sio_filter

// ===== design/sio_emul.sv
// platinum to silicon sensor resistance emulation
`timescale 1ns/10ps
module sio_emul
    import sio_pkg::*;
#(
    parameter logic [15:0] PT_BASE = 16'h03E8,
    parameter logic [15:0] SI_BASE = 16'h07D0,
    parameter logic [7:0] SI_GAIN = 8'h30,
    parameter int SI_SHIFT = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire sio_pair_s res_in,
    output sio_pair_s res_out
);
    typedef struct packed {
        sio_pair_s res;
    } sio_emu_state_s;
    sio_emu_state_s s_r;
    sio_emu_state_s s_nxt;

    // linear fit around the base point; readings below it clamp to the base
    function automatic logic [15:0] convert(input logic [15:0] r);
        logic [23:0] d;
        d = (r > PT_BASE) ? 24'(r - PT_BASE) * 24'(SI_GAIN) : 24'h000000;
        return 16'(24'(SI_BASE) + (d >> SI_SHIFT));
    endfunction

    always_comb begin
        s_nxt.res = res_in;
        if (enable_in) begin
            s_nxt.res.ch0 = convert(res_in.ch0); // R14
            s_nxt.res.ch1 = convert(res_in.ch1); // R14
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign res_out = s_r.res;

    property p_bypass;
        @(posedge clk_in) disable iff (!rst_n_in)
        !enable_in |=> (res_out == $past(res_in));
    endproperty
    a_bypass: assert property (p_bypass) else $error("emulation off altered value"); // R14
endmodule // sio_emul

// ===== design/sio_server.sv
// simple io resource server behind a byte register port
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "sio_consts.svh"
// Contract
// R1: io access resource 200h, uint32, levels 0
// R2: direct read returns defining values, offsets 0-5
// R3: wrong direction access rejected with 41h
// R4: payload byte 3 carries io level
// R5: offset selects io number 0 to 127
// R6: management resource 201h, write needs level 2
// R7: offsets 0 and 1 select input filters
// R8: filter weight is percentage 1 to 100
// R9: weight 100 bypasses, 50 blends equally
// R10: weight 1 gives one percent influence
// R11: weight in byte 0, others reserved
// R12: offset 100h write switches emulation
// R13: offset 100h read returns emulation state
// R14: emulation converts platinum to silicon resistance
// R15: master waits release flag between accesses
// R16: reserved value or offset rejected, unchanged
module sio_server
    import sio_pkg::*;
#(
    parameter int N_IO = 128,
    parameter logic [N_IO-1:0] IO_OUTPUT_MASK = N_IO'(1),
    parameter logic [7:0] TIMEOUT = 8'h0A,
    parameter logic [63:0] ACCESS_NAME = 64'h53494F5F41434345, // arbitrary
    parameter logic [63:0] MANAGE_NAME = 64'h53494F5F4D474D54 // arbitrary
) (
    input wire logic CLOCK_IN,
    input wire logic RESETN_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WRITE_IN,
    input wire logic READ_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic [2:0] ACCESS_LEVEL_IN,
    input wire logic [N_IO-1:0] IO_IN,
    output logic [N_IO-1:0] IO_OUT,
    input wire logic SAMPLE_VALID_IN,
    input wire sio_pair_s SAMPLE_IN,
    output sio_pair_s TEMP_OUT,
    output logic IRQ_OUT
);
    typedef struct packed {
        logic [7:0][7:0] payload;
        logic [7:0] addr_h;
        logic [7:0] addr_l;
        logic [7:0] offs_h;
        logic [7:0] offs_l;
        logic launch;
        logic release_flag;
        logic error;
        logic [7:0] err_code;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [N_IO-1:0] io_out;
        sio_weights_t weights;
        logic emul_on;
        logic [7:0] rdata;
    } sio_state_s;
    sio_state_s s_r;
    sio_state_s s_nxt;

    sio_msg_s msg;
    sio_pair_s filtered;
    logic is_acc;
    logic is_mg;
    logic io_ok;
    logic io_is_out;
    logic [6:0] io_idx;
    logic lvl_ok;
    logic wgt_ok;
    logic rsv_zero;

    assign msg.read = s_r.addr_h[`SIO_BIT_READ];
    assign msg.indirect = s_r.addr_h[`SIO_BIT_INDIRECT];
    assign msg.resource_identifier = {s_r.addr_h[1:0], s_r.addr_l};
    assign msg.offset = {s_r.offs_h[6:0], s_r.offs_l};
    assign is_acc = (msg.resource_identifier == `SIO_RID_ACCESS); // R1
    assign is_mg = (msg.resource_identifier == `SIO_RID_MANAGE); // R6
    assign io_idx = msg.offset[6:0];
    // io numbers beyond the fitted count are refused like reserved ones
    assign io_ok = (msg.offset <= `SIO_IO_MAX) && (msg.offset < 15'(N_IO)); // R5
    assign io_is_out = IO_OUTPUT_MASK[io_idx];
    assign lvl_ok = ({5'h00, ACCESS_LEVEL_IN} >= `SIO_MANAGE_WR_LEVEL); // R6
    assign wgt_ok = (s_r.payload[0] >= `SIO_WEIGHT_MIN) && (s_r.payload[0] <= `SIO_WEIGHT_MAX); // R11
    assign rsv_zero = (s_r.payload[1] == 8'h00) && (s_r.payload[2] == 8'h00);

    // defining value by offset; numbers land in byte 3, the low byte of the uint32
    function automatic logic [7:0] def_value(input logic [2:0] offs, input logic mg,
                                             input logic [7:0] tmo);
        logic [7:0] v;
        case (offs)
            3'h1: v = `SIO_DATA_SIZE;
            3'h2: v = mg ? `SIO_MANAGE_RD_LEVEL : `SIO_ACCESS_RD_LEVEL;
            3'h3: v = mg ? `SIO_MANAGE_WR_LEVEL : `SIO_ACCESS_WR_LEVEL;
            3'h4: v = tmo;
            3'h5: v = `SIO_DATA_TYPE;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [7:0] err;
        logic done;
        err = `SIO_ERR_NONE;
        done = 1'b0;
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (WRITE_IN) begin
            if (ADDR_IN <= `SIO_OFF_PAYLOAD_LAST) begin
                s_nxt.payload[ADDR_IN[2:0]] = WDATA_IN;
            end
            case (ADDR_IN)
                `SIO_OFF_ADDR_HIGH: s_nxt.addr_h = WDATA_IN;
                `SIO_OFF_ADDR_LOW: s_nxt.addr_l = WDATA_IN;
                `SIO_OFF_OFFS_HIGH: s_nxt.offs_h = WDATA_IN;
                `SIO_OFF_OFFS_LOW: s_nxt.offs_l = WDATA_IN;
                `SIO_OFF_IRQ_MASK: s_nxt.irq_mask = WDATA_IN[1:0];
                `SIO_OFF_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~WDATA_IN[1:0];
                `SIO_OFF_CTRL: begin
                    // a launch while busy is dropped; the master must wait for release
                    if (WDATA_IN[`SIO_BIT_LAUNCH] && s_r.release_flag) begin // R15
                        s_nxt.launch = 1'b1;
                        s_nxt.release_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (s_r.launch) begin
            done = 1'b1;
            if (!is_acc && !is_mg) begin
                err = `SIO_ERR_RID;
            end else if (!msg.indirect) begin
                if (!msg.read) begin
                    err = `SIO_ERR_ACCESS;
                end else if (msg.offset == 15'h0000) begin
                    s_nxt.payload = is_mg ? MANAGE_NAME : ACCESS_NAME; // R2
                end else if (msg.offset <= 15'h0005) begin
                    s_nxt.payload = '0;
                    s_nxt.payload[3] = def_value(msg.offset[2:0], is_mg, TIMEOUT); // R1 R2
                end else begin
                    err = `SIO_ERR_RANGE;
                end
            end else if (is_acc) begin
                if (!io_ok) begin
                    err = `SIO_ERR_RANGE; // R5
                end else if (msg.read == io_is_out) begin
                    err = `SIO_ERR_DIRECTION; // R3
                end else if (msg.read) begin
                    s_nxt.payload = '0;
                    s_nxt.payload[3] = {7'h00, IO_IN[io_idx]}; // R4
                end else if (!rsv_zero || s_r.payload[0] != 8'h00
                             || s_r.payload[3] > `SIO_LEVEL_HIGH) begin
                    err = `SIO_ERR_VALUE; // R16
                end else begin
                    s_nxt.io_out[io_idx] = s_r.payload[3][0]; // R4 R5
                end
            end else if (msg.read) begin
                s_nxt.payload = '0;
                if (msg.offset == `SIO_MG_FILTER0 || msg.offset == `SIO_MG_FILTER1) begin
                    s_nxt.payload[0] = {1'b0, s_r.weights[msg.offset[0]]}; // R7
                end else if (msg.offset == `SIO_MG_EMUL) begin
                    s_nxt.payload[3] = {7'h00, s_r.emul_on}; // R13
                end else begin
                    s_nxt.payload = s_r.payload;
                    err = `SIO_ERR_RANGE;
                end
            end else if (!lvl_ok) begin
                err = `SIO_ERR_LEVEL; // R6
            end else if (msg.offset == `SIO_MG_FILTER0 || msg.offset == `SIO_MG_FILTER1) begin
                if (!wgt_ok || !rsv_zero || s_r.payload[3] != 8'h00) begin
                    err = `SIO_ERR_VALUE; // R11 R16
                end else begin
                    s_nxt.weights[msg.offset[0]] = s_r.payload[0][6:0]; // R7 R8
                end
            end else if (msg.offset == `SIO_MG_EMUL) begin
                if (!rsv_zero || s_r.payload[0] != 8'h00
                    || s_r.payload[3] > `SIO_LEVEL_HIGH) begin
                    err = `SIO_ERR_VALUE; // R16
                end else begin
                    s_nxt.emul_on = s_r.payload[3][0]; // R12
                end
            end else begin
                err = `SIO_ERR_RANGE; // R7 R16
            end
            s_nxt.launch = 1'b0;
            s_nxt.release_flag = 1'b1; // R15
            s_nxt.error = (err != `SIO_ERR_NONE);
            s_nxt.err_code = err; // R3
        end
        // completion and error events; setting wins over a clear in the same cycle
        s_nxt.irq_stat = s_nxt.irq_stat | {err != `SIO_ERR_NONE, done};
        if (READ_IN) begin
            if (ADDR_IN <= `SIO_OFF_PAYLOAD_LAST) begin
                s_nxt.rdata = s_r.payload[ADDR_IN[2:0]];
            end
            case (ADDR_IN)
                `SIO_OFF_ADDR_HIGH: s_nxt.rdata = s_r.addr_h;
                `SIO_OFF_ADDR_LOW: s_nxt.rdata = s_r.addr_l;
                `SIO_OFF_OFFS_HIGH: s_nxt.rdata = s_r.offs_h;
                `SIO_OFF_OFFS_LOW: s_nxt.rdata = s_r.offs_l;
                `SIO_OFF_STATUS: s_nxt.rdata = {6'h00, s_r.error, s_r.release_flag};
                `SIO_OFF_ERROR: s_nxt.rdata = s_r.err_code;
                `SIO_OFF_IRQ_STAT: s_nxt.rdata = {6'h00, s_r.irq_stat};
                `SIO_OFF_IRQ_MASK: s_nxt.rdata = {6'h00, s_r.irq_mask};
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            s_r <= '0;
            s_r.release_flag <= 1'b1;
            s_r.weights <= {`SIO_WEIGHT_RESET, `SIO_WEIGHT_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    sio_filter u_filter (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESETN_IN),
        .valid_in(SAMPLE_VALID_IN),
        .sample_in(SAMPLE_IN),
        .weight_in(s_r.weights), // R8 R9 R10
        .avg_out(filtered)
    );

    sio_emul u_emul (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESETN_IN),
        .enable_in(s_r.emul_on), // R14
        .res_in(filtered),
        .res_out(TEMP_OUT)
    );

    assign RDATA_OUT = s_r.rdata;
    assign IO_OUT = s_r.io_out;
    assign IRQ_OUT = |(s_r.irq_stat & s_r.irq_mask);

    sequence s_launch_req;
        WRITE_IN && ADDR_IN == `SIO_OFF_CTRL && WDATA_IN[`SIO_BIT_LAUNCH] && s_r.release_flag;
    endsequence
    sequence s_busy_then_free;
        !s_r.release_flag ##1 s_r.release_flag;
    endsequence
    property p_release;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        s_launch_req |=> s_busy_then_free;
    endproperty
    a_release: assert property (p_release) else $error("release flag sequence wrong"); // R15

    property p_direction;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && is_acc && msg.indirect && io_ok && msg.read == io_is_out)
            |=> (s_r.err_code == `SIO_ERR_DIRECTION && s_r.io_out == $past(s_r.io_out));
    endproperty
    a_direction: assert property (p_direction) else $error("direction error missing"); // R3

    property p_level;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && is_mg && msg.indirect && !msg.read && !lvl_ok)
            |=> (s_r.err_code == `SIO_ERR_LEVEL && $stable(s_r.weights));
    endproperty
    a_level: assert property (p_level) else $error("low level write not refused"); // R6

    property p_io_write;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && is_acc && msg.indirect && !msg.read && io_ok && io_is_out
         && s_r.payload[3] == `SIO_LEVEL_HIGH && rsv_zero && s_r.payload[0] == 8'h00)
            |=> ##1 IO_OUT[$past(io_idx, 2)];
    endproperty
    a_io_write: assert property (p_io_write) else $error("output not driven high"); // R4

    property p_emul_read;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && is_mg && msg.indirect && msg.read && msg.offset == `SIO_MG_EMUL)
            |=> (s_r.payload[3] == {7'h00, s_r.emul_on} && s_r.payload[0] == 8'h00);
    endproperty
    a_emul_read: assert property (p_emul_read) else $error("emulation state not reported"); // R13

    property p_bad_weight;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && is_mg && msg.indirect && !msg.read && lvl_ok
         && msg.offset == `SIO_MG_FILTER0 && !wgt_ok)
            |=> (s_r.error && $stable(s_r.weights));
    endproperty
    a_bad_weight: assert property (p_bad_weight) else $error("reserved weight accepted"); // R16

    property p_direct_type;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && (is_acc || is_mg) && !msg.indirect && msg.read && msg.offset == 15'h0005)
            |=> (s_r.payload[3] == `SIO_DATA_TYPE && !s_r.error);
    endproperty
    a_direct_type: assert property (p_direct_type) else $error("data type value wrong"); // R2

    property p_weight_set;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (s_r.launch && is_mg && msg.indirect && !msg.read && lvl_ok && wgt_ok && rsv_zero
         && s_r.payload[3] == 8'h00 && msg.offset == `SIO_MG_FILTER1)
            |=> (s_r.weights[1] == $past(s_r.payload[0][6:0]));
    endproperty
    a_weight_set: assert property (p_weight_set) else $error("filter weight not stored"); // R7
endmodule // sio_server

// ===== tb/sio_master_model.sv
// drive side master model issuing message accesses over the register port
`timescale 1ns/10ps
module sio_master_model (
    input wire logic clk_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic write_out,
    output logic read_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        write_out = 1'b0;
        read_out = 1'b0;
    end
    // strobes stay up between back-to-back calls, so no signal is assigned twice per step
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        addr_out <= a;
        wdata_out <= d;
        write_out <= 1'b1;
        read_out <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic get(input logic [7:0] a);
        addr_out <= a;
        write_out <= 1'b0;
        read_out <= 1'b1;
        @(posedge clk_in);
    endtask
    task automatic idle();
        write_out <= 1'b0;
        read_out <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic msg(input logic r, input logic ind, input logic [9:0] id,
            input logic [15:0] o, input logic [63:0] p);
        for (int i = 0; i < 8; i++) begin
            put(i[7:0], p[8*i +: 8]);
        end
        put(8'h08, {1'b0, r, ind, 3'b110, id[9:8]});
        put(8'h09, id[7:0]);
        put(8'h0A, o[15:8]);
        put(8'h0B, o[7:0]);
        put(8'h0C, 8'h01);
        idle();
        // flag is back one edge after the launch write; two spare edges before the next access
        repeat (2) @(posedge clk_in);
    endtask
endmodule // sio_master_model

// ===== tb/test_sio_server.sv
// self-checking bench of the simple io resource server
`timescale 1ns/10ps
`include "sio_consts.svh"
module test_sio_server;
    import sio_pkg::*;
    localparam logic [9:0] ACC = 10'h200;
    localparam logic [9:0] MNG = 10'h201;
    logic clk, rst_n, wr, rd, svalid, irq;
    logic rd_seen = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] level;
    logic [127:0] io_in, io_out;
    sio_pair_s samp, temp;
    logic [31:0] seed;
    logic [15:0] ent;
    logic [15:0] exp_q[$];
    int miscompares, n_tests, cycles, n, x0, y0, x1, y1;
    sio_server sio_server_inst (.CLOCK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WRITE_IN(wr), .READ_IN(rd), .RDATA_OUT(rdata),
        .ACCESS_LEVEL_IN(level), .IO_IN(io_in), .IO_OUT(io_out), .SAMPLE_VALID_IN(svalid),
        .SAMPLE_IN(samp), .TEMP_OUT(temp), .IRQ_OUT(irq));
    sio_master_model sio_master_model_inst (.clk_in(clk), .addr_out(addr),
        .wdata_out(wdata), .write_out(wr), .read_out(rd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // names are the arbitrary parameter defaults; timeout is the default 0Ah
    function automatic logic [7:0] dv(input int r, input int o);
        logic [7:0] t [6];
        t = '{r ? 8'h54 : 8'h45, 8'h04, 8'h00, r ? 8'h02 : 8'h00, 8'h0A, 8'h05};
        return t[o];
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // read whose data the monitor compares one cycle later, under a mask
    task automatic ex(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e});
        sio_master_model_inst.get(a);
        sio_master_model_inst.idle();
    endtask
    task automatic done(input logic [7:0] c, input logic [7:0] m);
        ex(8'h0D, {6'h00, c != 8'h00, 1'b1}, 8'hFF);
        ex(8'h0E, c, m);
    endtask
    task automatic ms(input logic r, input logic [9:0] id, input logic [15:0] o,
            input logic [63:0] p, input logic [7:0] c, input logic [7:0] m);
        sio_master_model_inst.msg(r, 1'b1, id, o, p);
        done(c, m);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        sio_master_model_inst.put(a, d);
        sio_master_model_inst.idle();
        sio_master_model_inst.idle();
    endtask
    task automatic send(input int a, input int b);
        samp <= {b[15:0], a[15:0]};
        svalid <= 1'b1;
        @(posedge clk);
        svalid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("[FAIL] %0t run timed out", $time);
            end_sim();
        end
    end
    always @(posedge clk) begin
        if (rd_seen) begin
            ent = exp_q.pop_front();
            cmp({24'h0, rdata & ent[15:8]}, {24'h0, ent[7:0] & ent[15:8]}, "read data");
        end
        rd_seen <= rd;
    end
    initial begin
        rst_n = 1'b0;
        level = 3'h0;
        svalid = 1'b0;
        samp = '0;
        seed = 32'h000125C8;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            io_in[32*i +: 32] = seed;
        end
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        done(8'h00, 8'hFF);
        ex(8'h40, 8'h00, 8'hFF);
        cmp({31'h0, irq}, 32'h0, "irq after reset");
        cmp(io_out[31:0], 32'h0, "outputs after reset");
        $display("test reset done");
        for (int r = 0; r < 2; r++) begin
            for (int o = 0; o < 6; o++) begin
                sio_master_model_inst.msg(1'b1, 1'b0, r ? MNG : ACC, 16'(o), 64'h0);
                done(8'h00, 8'hFF);
                ex(o == 0 ? 8'h00 : 8'h03, dv(r, o), 8'hFF);
            end
        end
        $display("test defining values done");
        ms(1'b0, ACC, 16'h0000, 64'h01000000, 8'h00, 8'hFF);
        cmp(io_out[31:0], 32'h1, "output driven high");
        ms(1'b0, ACC, 16'h0000, 64'h0, 8'h00, 8'hFF);
        cmp(io_out[31:0], 32'h0, "output driven low");
        ms(1'b1, ACC, 16'h0000, 64'h0, `SIO_ERR_DIRECTION, 8'hFF);
        ms(1'b0, ACC, 16'h0005, 64'h01000000, `SIO_ERR_DIRECTION, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            n = (k == 3) ? 127 : 1 + seed[6:0] % 127;
            ms(1'b1, ACC, 16'(n), 64'h0, 8'h00, 8'hFF);
            ex(8'h03, {7'h0, io_in[n]}, 8'hFF);
        end
        ms(1'b1, ACC, 16'h0080, 64'h0, `SIO_ERR_RANGE, 8'hFF);
        ms(1'b1, 10'h202, 16'h0000, 64'h0, `SIO_ERR_RID, 8'hFF);
        sio_master_model_inst.msg(1'b0, 1'b0, ACC, 16'h0000, 64'h01000000);
        done(`SIO_ERR_ACCESS, 8'hFF);
        ms(1'b0, ACC, 16'h0000, 64'h02000000, `SIO_ERR_VALUE, 8'hFF);
        ms(1'b0, ACC, 16'h0000, 64'h01000001, `SIO_ERR_VALUE, 8'hFF);
        cmp(io_out[31:0], 32'h0, "output kept after refusals");
        $display("test io access done");
        seed = lfsr(seed);
        x0 = seed[15:0];
        y0 = seed[31:16];
        send(x0, y0);
        cmp(temp, {y0[15:0], x0[15:0]}, "unfiltered sample");
        level <= 3'h1;
        ms(1'b0, MNG, 16'h0000, 64'h32, `SIO_ERR_LEVEL, 8'hFF);
        level <= 3'h2;
        ms(1'b0, MNG, 16'h0000, 64'h32, 8'h00, 8'hFF);
        ms(1'b0, MNG, 16'h0001, 64'h01, 8'h00, 8'hFF);
        ms(1'b0, MNG, 16'h0000, 64'h00, `SIO_ERR_VALUE, 8'hFF);
        ms(1'b0, MNG, 16'h0000, 64'h65, `SIO_ERR_VALUE, 8'hFF);
        ms(1'b0, MNG, 16'h0000, 64'hFF, `SIO_ERR_VALUE, 8'hFF);
        ms(1'b0, MNG, 16'h0000, 64'h0132, `SIO_ERR_VALUE, 8'hFF);
        ms(1'b0, MNG, 16'h0002, 64'h32, `SIO_ERR_RANGE, 8'hFF);
        ms(1'b1, MNG, 16'h0000, 64'h0, 8'h00, 8'hFF);
        ex(8'h00, 8'h32, 8'hFF);
        ms(1'b1, MNG, 16'h0001, 64'h0, 8'h00, 8'hFF);
        ex(8'h00, 8'h01, 8'hFF);
        seed = lfsr(seed);
        x1 = seed[15:0];
        y1 = seed[31:16];
        send(x1, y1);
        cmp({16'h0, temp.ch0}, (50 * x1 + 50 * x0) / 100, "half weight");
        cmp({16'h0, temp.ch1}, (y1 + 99 * y0) / 100, "one percent weight");
        $display("test filter done");
        ms(1'b0, MNG, 16'h0000, 64'h64, 8'h00, 8'hFF);
        ms(1'b1, MNG, 16'h8100, 64'h0, 8'h00, 8'hFF);
        ex(8'h03, 8'h00, 8'hFF);
        ms(1'b0, MNG, 16'h8100, 64'h01000000, 8'h00, 8'hFF);
        ms(1'b1, MNG, 16'h8100, 64'h0, 8'h00, 8'hFF);
        ex(8'h03, 8'h01, 8'hFF);
        // emulation defaults: one step of 10h above the base maps to 0800h
        send(32'h03F8, y1);
        cmp({16'h0, temp.ch0}, 32'h0800, "emulated value");
        ms(1'b0, MNG, 16'h8100, 64'h0, 8'h00, 8'hFF);
        send(x1, y1);
        cmp({16'h0, temp.ch0}, x1, "emulation off");
        $display("test emulation done");
        wreg(8'h0F, 8'h03);
        wreg(8'h10, 8'h01);
        cmp({31'h0, irq}, 32'h0, "irq cleared");
        ms(1'b1, ACC, 16'h0000, 64'h0, `SIO_ERR_DIRECTION, 8'hFF);
        ex(8'h0F, 8'h03, 8'hFF);
        cmp({31'h0, irq}, 32'h1, "irq on done");
        wreg(8'h0F, 8'h01);
        cmp({31'h0, irq}, 32'h0, "error bit masked");
        wreg(8'h10, 8'h03);
        cmp({31'h0, irq}, 32'h1, "error bit unmasked");
        wreg(8'h0F, 8'h02);
        cmp({31'h0, irq}, 32'h0, "irq cleared again");
        $display("test interrupt done");
        end_sim();
    end
endmodule // test_sio_server
